// ==== hdl/sdde_pkg.sv ====
// Constants and types for the dual element SIMD datapath
package sdde_pkg;
  localparam int REG_W = 40;
  localparam int BUS_W = 64;
  localparam int FIX_W = 32;
  localparam int FIX_LSB = 8;
  localparam int NREG = 16;
  localparam int NPHYS = 32;
  localparam int NLANE = 2;
  localparam int FIRST_MODE_CONTROL_REGISTER_W = 4;
  localparam int M1_SEC_RF = 0;
  localparam int M1_SEC_AG = 1;
  localparam int M1_SEC_MR = 2;
  localparam int M1_YEN = 3;
  localparam logic [3:0] FIRST_MODE_CONTROL_REGISTER_RST = 4'h0;
  localparam logic [9:0] FP_BIAS = 10'h07f;
  localparam logic [9:0] FP_EMAX = 10'h0ff;
  localparam logic [39:0] SGL_MASK = 40'hff_ffff_ff00;
  localparam logic [39:0] EXT_MASK = 40'hff_ffff_ffff;

  typedef enum logic [1:0] {
    FMT_FIX = 2'h0,
    FMT_SGL = 2'h1,
    FMT_EXT = 2'h2
  } sdde_fmt_t;

  typedef enum logic [2:0] {
    ALU_NOP = 3'h0,
    ALU_ADD = 3'h1,
    ALU_SUB = 3'h2,
    ALU_AND = 3'h3,
    ALU_OR = 3'h4,
    ALU_XOR = 3'h5,
    ALU_FABS = 3'h6,
    ALU_FNEG = 3'h7
  } sdde_alu_t;

  typedef enum logic [1:0] {
    MUL_NOP = 2'h0,
    MUL_FIX = 2'h1,
    MUL_MAC = 2'h2,
    MUL_FLT = 2'h3
  } sdde_mul_t;

  typedef enum logic [1:0] {
    SHF_NOP = 2'h0,
    SHF_LSH = 2'h1,
    SHF_ASH = 2'h2,
    SHF_ROT = 2'h3
  } sdde_shf_t;

  typedef enum logic [1:0] {
    XFER_NONE = 2'h0,
    XFER_LOAD = 2'h1,
    XFER_STORE = 2'h2
  } sdde_xfer_t;

  typedef enum logic [2:0] {
    PX_NONE = 3'h0,
    PX_FROM_PM = 3'h1,
    PX_FROM_DM = 3'h2,
    PX_TO_PM = 3'h3,
    PX_TO_DM = 3'h4,
    PX_FROM_RF = 3'h5,
    PX_TO_RF = 3'h6
  } sdde_px_t;
endpackage

// ==== hdl/sdde_pe_unit.sv ====
// One element's ALU, multiplier and shifter, all combinational
`timescale 1ns/1ps
module sdde_pe_unit (
  input wire sdde_pkg::sdde_fmt_t fmt_i,
  input wire sdde_pkg::sdde_alu_t alu_op_i,
  input wire sdde_pkg::sdde_mul_t mul_op_i,
  input wire sdde_pkg::sdde_shf_t shf_op_i,
  input wire logic [39:0] a_i,
  input wire logic [39:0] b_i,
  input wire logic [39:0] c_i,
  input wire logic [63:0] mr_i,
  output logic [39:0] alu_res_o,
  output logic [2:0] alu_flags_o,
  output logic [39:0] mul_res_o,
  output logic [63:0] mr_next_o,
  output logic [39:0] shf_res_o
);
  import sdde_pkg::*;
  logic [31:0] fa;
  logic [31:0] fb;
  logic [32:0] sum;
  logic [39:0] keep;
  logic [63:0] prod;
  logic [63:0] fp_p;
  logic [9:0] fp_e;
  logic [39:0] fp_r;
  logic [7:0] amt;
  logic [31:0] sh_r;
  logic av;

  // Fixed point data sits in the upper 32 bits of a 40-bit register
  assign fa = a_i[39:8];
  assign fb = b_i[39:8];
  assign keep = (fmt_i == FMT_SGL) ? SGL_MASK : EXT_MASK;

  always_comb begin
    sum = 33'h0;
    alu_res_o = 40'h0;
    av = 1'b0;
    case (alu_op_i)
      ALU_ADD: begin
        sum = {fa[31], fa} + {fb[31], fb};
        alu_res_o = {sum[31:0], 8'h00};
        av = sum[32] ^ sum[31];
      end
      ALU_SUB: begin
        sum = {fa[31], fa} - {fb[31], fb};
        alu_res_o = {sum[31:0], 8'h00};
        av = sum[32] ^ sum[31];
      end
      ALU_AND: alu_res_o = {fa & fb, 8'h00};
      ALU_OR: alu_res_o = {fa | fb, 8'h00};
      ALU_XOR: alu_res_o = {fa ^ fb, 8'h00};
      ALU_FABS: alu_res_o = {1'b0, a_i[38:0]} & keep;
      ALU_FNEG: alu_res_o = {~a_i[39], a_i[38:0]} & keep;
      default: alu_res_o = 40'h0;
    endcase
    alu_flags_o = {av, alu_res_o[39], alu_res_o == 40'h0};
  end

  // Float multiply flushes tiny results to zero, no rounding
  always_comb begin
    // Extend first so the full 64-bit product reaches the accumulator
    prod = $signed({{32{fa[31]}}, fa}) * $signed({{32{fb[31]}}, fb});
    mr_next_o = mr_i + prod;
    fp_p = {1'b1, a_i[30:0]} * {1'b1, b_i[30:0]};
    fp_e = {2'h0, a_i[38:31]} + {2'h0, b_i[38:31]} - FP_BIAS
      + {9'h0, fp_p[63]};
    if (a_i[38:31] == 8'h00 || b_i[38:31] == 8'h00 || fp_e[9]
        || fp_e == 10'h0) begin
      fp_r = {a_i[39] ^ b_i[39], 39'h0};
    end else if (fp_e >= FP_EMAX) begin
      fp_r = {a_i[39] ^ b_i[39], 8'hff, 31'h0};
    end else begin
      fp_r = {a_i[39] ^ b_i[39], fp_e[7:0],
        fp_p[63] ? fp_p[62:32] : fp_p[61:31]};
    end
    case (mul_op_i)
      MUL_FIX: mul_res_o = {prod[31:0], 8'h00};
      MUL_MAC: mul_res_o = {mr_next_o[31:0], 8'h00};
      MUL_FLT: mul_res_o = fp_r & keep;
      default: mul_res_o = 40'h0;
    endcase
  end

  // Signed amount: positive shifts left, negative shifts right
  always_comb begin
    amt = c_i[7 + FIX_LSB:FIX_LSB];
    case (shf_op_i)
      SHF_LSH: sh_r = amt[7] ? fa >> (8'h0 - amt) : fa << amt;
      SHF_ASH: sh_r = amt[7] ? 32'($signed(fa) >>> (8'h0 - amt))
        : fa << amt;
      SHF_ROT: sh_r = (fa << amt[4:0]) | (fa >> (6'h20 - {1'b0, amt[4:0]}));
      default: sh_r = 32'h0;
    endcase
    shf_res_o = {sh_r, 8'h00};
  end
endmodule

// ==== hdl/sdde_core.sv ====
// Dual element SIMD datapath: register files, exchange register, buses
// Notes on behaviour
// - X lane always runs; Y lane when enabled
// - Both lanes execute the same instruction together
// - SIMD bus transfers carry one word per lane
// - ALU, multiplier, shifter finish in one cycle
// - ALU and multiplier operate in parallel
// - Fixed, single and extended float formats
// - Each lane has 32 registers, two banks
// - Primary banks after reset; mode bits switch
// - Exchange register bridges buses and register file
// - Both 64-bit buses can transfer in the same cycle
`timescale 1ns/1ps
module sdde_core (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic first_mode_control_register_we_i,
  input wire logic [3:0] first_mode_control_register_i,
  input wire logic instr_valid_i,
  input wire sdde_pkg::sdde_fmt_t fmt_i,
  input wire sdde_pkg::sdde_alu_t alu_op_i,
  input wire sdde_pkg::sdde_mul_t mul_op_i,
  input wire sdde_pkg::sdde_shf_t shf_op_i,
  input wire logic [3:0] src_a_i,
  input wire logic [3:0] src_b_i,
  input wire logic [3:0] src_c_i,
  input wire logic [3:0] dst_alu_i,
  input wire logic [3:0] dst_mul_i,
  input wire logic [3:0] dst_shf_i,
  input wire sdde_pkg::sdde_xfer_t pm_xfer_i,
  input wire logic [3:0] pm_reg_i,
  input wire logic [63:0] pm_rdata_i,
  input wire sdde_pkg::sdde_xfer_t dm_xfer_i,
  input wire logic [3:0] dm_reg_i,
  input wire logic [63:0] dm_rdata_i,
  input wire sdde_pkg::sdde_px_t px_cmd_i,
  input wire logic [3:0] px_reg_i,
  output logic [3:0] first_mode_control_register_o,
  output logic [63:0] pm_wdata_o,
  output logic pm_wvalid_o,
  output logic [63:0] dm_wdata_o,
  output logic dm_wvalid_o,
  output logic [63:0] px_o,
  output logic [2:0] x_flags_o,
  output logic [2:0] y_flags_o,
  output logic [63:0] x_mr_o,
  output logic [63:0] y_mr_o
);
  import sdde_pkg::*;

  typedef struct packed {
    logic [3:0] first_mode_control_register;
    logic [63:0] px;
    logic [63:0] pm_wdata;
    logic pm_wvalid;
    logic [63:0] dm_wdata;
    logic dm_wvalid;
    logic [1:0][2:0] flags;
    logic [1:0][63:0] mr_out;
    logic [1:0][1:0][63:0] mr;
    logic [1:0][31:0][39:0] rf;
  } sdde_state_t;

  sdde_state_t s;
  sdde_state_t next_s;

  logic yen;
  logic sec_rf;
  logic sec_mr;
  logic [4:0] p_a;
  logic [4:0] p_b;
  logic [4:0] p_c;
  logic [4:0] p_alu;
  logic [4:0] p_mul;
  logic [4:0] p_shf;
  logic [4:0] p_pm;
  logic [4:0] p_dm;
  logic [4:0] p_px;
  logic [1:0][39:0] alu_res;
  logic [1:0][2:0] alu_flg;
  logic [1:0][39:0] mul_res;
  logic [1:0][63:0] mr_next;
  logic [1:0][39:0] shf_res;

  assign yen = s.first_mode_control_register[M1_YEN];
  assign sec_rf = s.first_mode_control_register[M1_SEC_RF];
  assign sec_mr = s.first_mode_control_register[M1_SEC_MR];

  // Bank bit picks primary or secondary half of the 32 registers
  function automatic logic [4:0] phys(input logic sec,
    input logic [3:0] idx);
    return {sec, idx};
  endfunction

  assign p_a = phys(sec_rf, src_a_i);
  assign p_b = phys(sec_rf, src_b_i);
  assign p_c = phys(sec_rf, src_c_i);
  assign p_alu = phys(sec_rf, dst_alu_i);
  assign p_mul = phys(sec_rf, dst_mul_i);
  assign p_shf = phys(sec_rf, dst_shf_i);
  assign p_pm = phys(sec_rf, pm_reg_i);
  assign p_dm = phys(sec_rf, dm_reg_i);
  assign p_px = phys(sec_rf, px_reg_i);

  // Both lanes see one decoded instruction, each its own operands
  for (genvar e = 0; e < NLANE; e++) begin : g_lane
    sdde_pe_unit u_pe (
      .fmt_i(fmt_i),
      .alu_op_i(alu_op_i),
      .mul_op_i(mul_op_i),
      .shf_op_i(shf_op_i),
      .a_i(s.rf[e][p_a]),
      .b_i(s.rf[e][p_b]),
      .c_i(s.rf[e][p_c]),
      .mr_i(s.mr[e][sec_mr]),
      .alu_res_o(alu_res[e]),
      .alu_flags_o(alu_flg[e]),
      .mul_res_o(mul_res[e]),
      .mr_next_o(mr_next[e]),
      .shf_res_o(shf_res[e])
    );
  end

  // SIMD splits a bus word into two 32-bit lane values
  function automatic logic [39:0] lane_word(input logic [63:0] d,
    input logic hi, input logic simd);
    if (!simd) begin
      return d[39:0];
    end
    return hi ? {d[63:32], 8'h00} : {d[31:0], 8'h00};
  endfunction

  function automatic logic [63:0] pack_word(input logic [39:0] x,
    input logic [39:0] y, input logic simd);
    return simd ? {y[39:8], x[39:8]} : {24'h0, x};
  endfunction

  // Write order: shifter, multiplier, ALU, DM load, PM load, exchange.
  // A later writer wins a register collision within one cycle.
  always_comb begin
    next_s = s;
    next_s.pm_wvalid = 1'b0;
    next_s.dm_wvalid = 1'b0;
    if (first_mode_control_register_we_i) begin
      next_s.first_mode_control_register = first_mode_control_register_i;
    end
    for (int e = 0; e < NLANE; e++) begin
      if (e == 0 || yen) begin
        if (instr_valid_i) begin
          if (shf_op_i != SHF_NOP) begin
            next_s.rf[e][p_shf] = shf_res[e];
          end
          if (mul_op_i != MUL_NOP) begin
            next_s.rf[e][p_mul] = mul_res[e];
          end
          if (mul_op_i == MUL_MAC) begin
            next_s.mr[e][sec_mr] = mr_next[e];
            next_s.mr_out[e] = mr_next[e];
          end
          if (alu_op_i != ALU_NOP) begin
            next_s.rf[e][p_alu] = alu_res[e];
            next_s.flags[e] = alu_flg[e];
          end
        end
        if (dm_xfer_i == XFER_LOAD) begin
          next_s.rf[e][p_dm] = lane_word(dm_rdata_i, e == 1, yen);
        end
        if (pm_xfer_i == XFER_LOAD) begin
          next_s.rf[e][p_pm] = lane_word(pm_rdata_i, e == 1, yen);
        end
      end
    end
    // Stores read the register file before this cycle's writes
    if (pm_xfer_i == XFER_STORE) begin
      next_s.pm_wdata = pack_word(s.rf[0][p_pm], s.rf[1][p_pm], yen);
      next_s.pm_wvalid = 1'b1;
    end
    if (dm_xfer_i == XFER_STORE) begin
      next_s.dm_wdata = pack_word(s.rf[0][p_dm], s.rf[1][p_dm], yen);
      next_s.dm_wvalid = 1'b1;
    end
    case (px_cmd_i)
      PX_FROM_PM: next_s.px = pm_rdata_i;
      PX_FROM_DM: next_s.px = dm_rdata_i;
      PX_TO_PM: begin
        next_s.pm_wdata = s.px;
        next_s.pm_wvalid = 1'b1;
      end
      PX_TO_DM: begin
        next_s.dm_wdata = s.px;
        next_s.dm_wvalid = 1'b1;
      end
      PX_FROM_RF: next_s.px = {24'h0, s.rf[0][p_px]};
      PX_TO_RF: next_s.rf[0][p_px] = s.px[39:0];
      default: next_s.px = s.px;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      s <= '0;
      s.first_mode_control_register <= FIRST_MODE_CONTROL_REGISTER_RST;
    end else begin
      s <= next_s;
    end
  end

  assign first_mode_control_register_o = s.first_mode_control_register;
  assign pm_wdata_o = s.pm_wdata;
  assign pm_wvalid_o = s.pm_wvalid;
  assign dm_wdata_o = s.dm_wdata;
  assign dm_wvalid_o = s.dm_wvalid;
  assign px_o = s.px;
  assign x_flags_o = s.flags[0];
  assign y_flags_o = s.flags[1];
  assign x_mr_o = s.mr_out[0];
  assign y_mr_o = s.mr_out[1];

  // Helper terms read only by the checks below
  logic rf_xfer_wr;
  logic only_alu;
  logic alu_mul;
  logic [31:0] pm_hi;
  logic [31:0] x_pm_hi;
  logic [31:0] y_pm_hi;
  logic [39:0] x_px_word;

  assign rf_xfer_wr = pm_xfer_i == XFER_LOAD || dm_xfer_i == XFER_LOAD
    || px_cmd_i == PX_TO_RF;
  assign only_alu = instr_valid_i && alu_op_i != ALU_NOP
    && mul_op_i == MUL_NOP && shf_op_i == SHF_NOP && !rf_xfer_wr;
  assign alu_mul = instr_valid_i && alu_op_i != ALU_NOP
    && mul_op_i != MUL_NOP && shf_op_i == SHF_NOP && !rf_xfer_wr
    && p_alu != p_mul;
  assign pm_hi = pm_rdata_i[63:32];
  assign x_pm_hi = s.rf[0][p_pm][39:8];
  assign y_pm_hi = s.rf[1][p_pm][39:8];
  assign x_px_word = s.rf[0][p_px];

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);

  a_y_lane_frozen: assert property (
    !yen |=> $stable(s.rf[1]) && $stable(s.flags[1]))
    else $error("Disabled y lane state changed");

  a_x_alu_cycle: assert property (
    only_alu |=> s.rf[0][$past(p_alu)] == $past(alu_res[0])
      && x_flags_o == $past(alu_flg[0]))
    else $error("X lane ALU result not written next cycle");

  a_y_lane_same: assert property (
    only_alu && yen |=> s.rf[1][$past(p_alu)] == $past(alu_res[1]))
    else $error("Y lane skipped the shared instruction");

  a_alu_mul_pair: assert property (
    alu_mul && yen |=> s.rf[0][$past(p_mul)] == $past(mul_res[0])
      && s.rf[1][$past(p_mul)] == $past(mul_res[1])
      && s.rf[1][$past(p_alu)] == $past(alu_res[1]))
    else $error("Parallel ALU and multiplier results lost");

  a_store_pair: assert property (
    pm_xfer_i == XFER_STORE && yen && px_cmd_i != PX_TO_PM
      |=> pm_wvalid_o && pm_wdata_o == {$past(y_pm_hi), $past(x_pm_hi)})
    else $error("SIMD store did not carry both lanes");

  a_load_pair: assert property (
    pm_xfer_i == XFER_LOAD && yen && px_cmd_i != PX_TO_RF
      |=> s.rf[1][$past(p_pm)] == {$past(pm_hi), 8'h00})
    else $error("SIMD load missed the y lane word");

  a_dual_bus: assert property (
    pm_xfer_i == XFER_STORE && dm_xfer_i == XFER_STORE
      |=> pm_wvalid_o && dm_wvalid_o)
    else $error("Both buses did not move data in one cycle");

  a_reset_primary: assert property (
    $rose(rst_n_i) |-> first_mode_control_register_o == FIRST_MODE_CONTROL_REGISTER_RST)
    else $error("Mode register not primary after reset");

  a_px_width: assert property (
    px_cmd_i == PX_FROM_RF |=> px_o == {24'h0, $past(x_px_word)})
    else $error("Exchange register width adaption wrong");

  a_single_mask: assert property (
    instr_valid_i && fmt_i == FMT_SGL && mul_op_i == MUL_FLT
      |-> mul_res[0][7:0] == 8'h00 && mul_res[1][7:0] == 8'h00)
    else $error("Single precision result has extended bits");

  c_simd_mac: cover property (
    instr_valid_i && yen && mul_op_i == MUL_MAC && alu_op_i != ALU_NOP);
  c_dual_store: cover property (
    yen && pm_xfer_i == XFER_STORE && dm_xfer_i == XFER_STORE);
  c_px_bridge: cover property (
    px_cmd_i == PX_FROM_PM ##1 px_cmd_i == PX_TO_DM);
  c_bank_swap: cover property (
    !sec_rf ##1 sec_rf && pm_xfer_i == XFER_LOAD);
endmodule

// ==== dv/sdde_bus_model.sv ====
// Memory side of one data bus: answers loads, scrambles when idle
`timescale 1ns/1ps
module sdde_bus_model (
  input wire logic clk_i,
  input wire logic rd_i,
  input wire logic [63:0] word_i,
  output logic [63:0] rdata_o
);
  logic [63:0] last;
  initial last = 64'h0;
  // Idle bus shows inverse of last word so no stale match can pass
  assign rdata_o = rd_i ? word_i : ~last;
  always @(posedge clk_i) begin
    if (rd_i) begin
      last <= word_i;
    end
  end
endmodule

// ==== dv/simd_dual_element_datapath_tb_top.sv ====
// Self-checking bench for the dual element datapath
`timescale 1ns/1ps
module simd_dual_element_datapath_tb_top;
  import sdde_pkg::*;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic we, iv;
  logic [3:0] m1, sa, sb, da, dmu, pr, drg, pxr;
  sdde_alu_t alu;
  sdde_mul_t mul;
  sdde_xfer_t pmx, dmx;
  sdde_px_t px;
  sdde_fmt_t fm;
  sdde_shf_t sh;
  logic [3:0] sc, ds;
  logic [63:0] pw, dw, prd, drd, pwd, dwd, pxo, xm, ym;
  logic pv, dv;
  logic [3:0] m1o;
  logic [2:0] xf, yf;
  int error_cnt = 0;
  int n_checks = 0;
  always #12.5 clk_i = ~clk_i;
  sdde_bus_model PMB (.clk_i(clk_i), .rd_i(pmx == XFER_LOAD),
    .word_i(pw), .rdata_o(prd));
  sdde_bus_model DMB (.clk_i(clk_i), .rd_i(dmx == XFER_LOAD),
    .word_i(dw), .rdata_o(drd));
  sdde_core DUT (.clk_i(clk_i), .rst_n_i(rst_n_i), .first_mode_control_register_we_i(we),
    .first_mode_control_register_i(m1), .instr_valid_i(iv), .fmt_i(fm), .alu_op_i(alu),
    .mul_op_i(mul), .shf_op_i(sh), .src_a_i(sa), .src_b_i(sb),
    .src_c_i(sc), .dst_alu_i(da), .dst_mul_i(dmu), .dst_shf_i(ds),
    .pm_xfer_i(pmx), .pm_reg_i(pr), .pm_rdata_i(prd), .dm_xfer_i(dmx),
    .dm_reg_i(drg), .dm_rdata_i(drd), .px_cmd_i(px), .px_reg_i(pxr),
    .first_mode_control_register_o(m1o), .pm_wdata_o(pwd), .pm_wvalid_o(pv), .dm_wdata_o(dwd),
    .dm_wvalid_o(dv), .px_o(pxo), .x_flags_o(xf), .y_flags_o(yf),
    .x_mr_o(xm), .y_mr_o(ym));
  task automatic idle();
    we = 1'b0; m1 = 4'h0; iv = 1'b0; alu = ALU_NOP; mul = MUL_NOP;
    sa = 4'h0; sb = 4'h0; da = 4'h0; dmu = 4'h0; pmx = XFER_NONE;
    dmx = XFER_NONE; pr = 4'h0; drg = 4'h0; px = PX_NONE; pxr = 4'h0;
    pw = 64'h0; dw = 64'h0;
    fm = FMT_FIX;
    sh = SHF_NOP;
    sc = 4'h0;
    ds = 4'h0;
  endtask
  task automatic cyc();
    @(posedge clk_i);
    #2;
    idle();
  endtask
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic mode(input logic [3:0] v);
    we = 1'b1; m1 = v; cyc();
    chk({60'h0, m1o}, {60'h0, v});
  endtask
  // Both buses load in one cycle: R1 from program bus, R2 from data bus
  task automatic ld(input logic [63:0] a, input logic [63:0] b);
    pmx = XFER_LOAD; pr = 4'h1; pw = a;
    dmx = XFER_LOAD; drg = 4'h2; dw = b;
    cyc();
  endtask
  task automatic st(input logic [3:0] r, input logic [63:0] exp);
    pmx = XFER_STORE; pr = r; cyc();
    chk({63'h0, pv}, 64'h1);
    chk(pwd, exp);
    cyc();
    chk({63'h0, pv}, 64'h0);
  endtask
  // ALU add into R3 and fixed multiply into R4 in one instruction
  task automatic add_mul();
    iv = 1'b1; alu = ALU_ADD; mul = MUL_FIX; sa = 4'h1; sb = 4'h2;
    da = 4'h3; dmu = 4'h4; cyc();
  endtask
  task automatic t_reset();
    chk({m1o, pv, dv, xf, yf}, 64'h0);
    chk(pxo | pwd | dwd | xm | ym, 64'h0);
  endtask
  task automatic t_scalar();
    ld(64'h0000_0000_0000_1100, 64'h0000_0000_0000_2200);
    add_mul();
    st(4'h3, 64'h0000_0000_0000_3300);
    st(4'h4, 64'h0000_0000_0002_4200);
    chk({61'h0, yf}, 64'h0);
  endtask
  task automatic t_simd();
    mode(4'h8);
    // Y lane was off during the scalar run, so its half stays zero
    st(4'h3, 64'h0000_0000_0000_0033);
    ld(64'h0000_0100_0000_0011, 64'h0000_0200_0000_0022);
    add_mul();
    st(4'h3, 64'h0000_0300_0000_0033);
    st(4'h4, 64'h0002_0000_0000_0242);
  endtask
  // MAC twice, shift with subtract, then a single float multiply
  task automatic t_units();
    iv = 1'b1;
    mul = MUL_MAC;
    sa = 4'h1;
    sb = 4'h2;
    dmu = 4'h5;
    cyc();
    chk(xm, 64'h242);
    chk(ym, 64'h2_0000);
    iv = 1'b1;
    mul = MUL_MAC;
    sa = 4'h1;
    sb = 4'h2;
    dmu = 4'h5;
    cyc();
    chk(xm, 64'h484);
    chk(ym, 64'h4_0000);
    iv = 1'b1;
    alu = ALU_SUB;
    sa = 4'h1;
    sb = 4'h1;
    da = 4'h8;
    sh = SHF_LSH;
    sc = 4'h1;
    ds = 4'h6;
    cyc();
    chk({61'h0, xf}, 64'h1);
    chk({61'h0, yf}, 64'h1);
    st(4'h6, 64'h0000_0100_0022_0000);
    ld(64'h3fc0_0000_3f80_0000, 64'h4000_0000_4000_0000);
    iv = 1'b1;
    fm = FMT_SGL;
    mul = MUL_FLT;
    sa = 4'h1;
    sb = 4'h2;
    dmu = 4'h7;
    cyc();
    st(4'h7, 64'h4040_0000_4000_0000);
  endtask
  task automatic t_exchange();
    px = PX_FROM_RF; pxr = 4'h3; cyc();
    chk(pxo, 64'h0000_0000_0000_3300);
    px = PX_TO_DM; cyc();
    chk({63'h0, dv}, 64'h1);
    chk(dwd, 64'h0000_0000_0000_3300);
    px = PX_FROM_PM; pmx = XFER_LOAD; pw = 64'h1234_5678_9abc_def0; cyc();
    chk(pxo, 64'h1234_5678_9abc_def0);
  endtask
  task automatic t_banks();
    mode(4'h9);
    st(4'h3, 64'h0);
    mode(4'h8);
    st(4'h3, 64'h0000_0300_0000_0033);
  endtask
  task automatic final_report();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  initial begin
    idle();
    repeat (16) @(posedge clk_i);
    #2;
    t_reset();
    rst_n_i = 1'b1;
    cyc();
    t_scalar();
    t_simd();
    t_units();
    t_exchange();
    t_banks();
    final_report();
  end
  // Whole sequence needs well under 100 cycles
  initial begin
    #100us;
    error_cnt++;
    final_report();
  end
endmodule
